// [rtl/aci_pkg.sv]
package aci_pkg;

    // ************************************************************
    // Register map (word index on the plain port)
    // ************************************************************
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_MAX_VELOCITY_LIMIT      = 4'h1;
    localparam logic [3:0] REG_VSCALE    = 4'h2;
    localparam logic [3:0] REG_DEADBAND  = 4'h3;
    localparam logic [3:0] REG_OFFSET    = 4'h4;
    localparam logic [3:0] REG_READING   = 4'h5;
    localparam logic [3:0] REG_STATUS    = 4'h6;
    localparam logic [3:0] REG_CMD       = 4'h7;
    localparam logic [3:0] REG_AZ_OFFSET = 4'h8;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          CTRL_DUAL_BIT   = 0;
    localparam int          CTRL_SEL_LSB    = 4;
    localparam int          CMD_ZERO_BIT    = 0;
    localparam int          CMD_SAVE_BIT    = 1;
    localparam logic        DUAL_RST        = 1'b1;
    localparam logic [3:0]  SEL_RST         = 4'h0;
    localparam logic [3:0]  SEL_ANALOG_VEL  = 4'h1;
    localparam logic [3:0]  SEL_ANALOG_TRQ  = 4'h3;
    localparam logic [15:0] MAX_VELOCITY_LIMIT_RST        = 16'h0C80;
    localparam logic [15:0] DEADBAND_RST    = 16'h0000;
    localparam logic [15:0] OFFSET_RST      = 16'h0000;

    // ************************************************************
    // Conversion constants
    // ************************************************************
    localparam int ADC_BITS      = 12;
    localparam int LOW_GAIN_MULT = 8;
    localparam int FULL_UNITS    = 16384;
    localparam int FULL_MV       = 10000;
    localparam int HI_EXIT_MV    = 1250;
    localparam int HI_ENTER_MV   = 1000;
    localparam logic [15:0] HI_EXIT_UNITS  =
        16'(HI_EXIT_MV * FULL_UNITS / FULL_MV);
    localparam logic [15:0] HI_ENTER_UNITS =
        16'(HI_ENTER_MV * FULL_UNITS / FULL_MV);
    localparam int SCALE_SHIFT   = 14;

    // ************************************************************
    // Auto-zero timing
    // ************************************************************
    localparam int AZ_TICK_NS    = 1000000;
    localparam int CLK_NS        = 100;
    localparam int AZ_TICK_CYC   = AZ_TICK_NS / CLK_NS;
    localparam int AZ_LOG2       = 8;
    localparam logic [15:0] AZ_DEADBAND_MV = 16'h0002;

    // Magnitude of a signed 16-bit value, saturated to 15 bits
    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        logic [15:0] m;
        m = v[15] ? 16'(-v) : 16'(v);
        if (m[15]) begin
            m = 16'h7FFF;
        end
        return m;
    endfunction : mag16

endpackage : aci_pkg

// [rtl/aci_gain_select.sv]
`timescale 1ns/10ps
module aci_gain_select (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        dual_gain_enable,
    input  wire logic        sample_valid,
    input  wire logic [15:0] magnitude,
    output logic             gain_high
);

    // ************************************************************
    // Hysteresis gain selector
    // ************************************************************
    // Two thresholds keep the selector from chattering at one level
    always_ff @(posedge clk) begin
        if (srst) begin
            gain_high <= 1'b1;
        end else if (!dual_gain_enable) begin
            gain_high <= 1'b0;
        end else if (sample_valid) begin
            // Top code clips just short of 1.25 V
            if (gain_high &&
                magnitude >= aci_pkg::HI_EXIT_UNITS - 16'h0001) begin
                gain_high <= 1'b0;
            end else if (!gain_high &&
                         magnitude < aci_pkg::HI_ENTER_UNITS) begin
                gain_high <= 1'b1;
            end
        end
    end

endmodule : aci_gain_select

// [rtl/aci_averager.sv]
`timescale 1ns/10ps
module aci_averager #(
    parameter int LOG2 = 8
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               start,
    input  wire logic               tick,
    input  wire logic signed [15:0] sample,
    output logic                    busy,
    output logic                    done,
    output logic signed [15:0]      average
);

    typedef enum logic [1:0] {
        ACI_AV_IDLE = 2'b01,
        ACI_AV_RUN  = 2'b10
    } aci_av_t;

    aci_av_t                   state;     // Sequencer state
    logic [LOG2:0]             count;     // Samples taken
    logic signed [LOG2+15:0]   sum;       // Running sum

    assign busy = (state == ACI_AV_RUN);

    // ************************************************************
    // Average 2**LOG2 velocity samples taken on each tick
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state   <= ACI_AV_IDLE;
            count   <= '0;
            sum     <= '0;
            done    <= 1'b0;
            average <= 16'sh0000;
        end else begin
            done <= 1'b0;
            unique case (state)
                ACI_AV_IDLE: begin
                    if (start) begin
                        state <= ACI_AV_RUN;
                        count <= '0;
                        sum   <= '0;
                    end
                end
                ACI_AV_RUN: begin
                    if (count[LOG2]) begin
                        // Power-of-two length makes the divide a shift
                        average <= 16'(sum >>> LOG2);
                        done    <= 1'b1;
                        state   <= ACI_AV_IDLE;
                    end else if (tick) begin
                        sum   <= sum + (LOG2+16)'(sample);
                        count <= count + 1'b1;
                    end
                end
            endcase
        end
    end

endmodule : aci_averager

// [rtl/aci_top.sv]
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module aci_top #(
    parameter int AZ_TICK_CYC = aci_pkg::AZ_TICK_CYC
) (
    input  wire logic               clk,
    input  wire logic               srst,
    // Register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [15:0]             reg_rdata,
    // Converter side
    input  wire logic               adc_valid,
    input  wire logic signed [11:0] adc_code,
    output logic                    front_gain_high,
    // Drive loops
    input  wire logic               drive_enabled,
    input  wire logic signed [15:0] motor_velocity,
    output logic signed [23:0]      vel_cmd,
    output logic                    vel_cmd_valid,
    output logic signed [15:0]      torque_cmd,
    output logic                    torque_cmd_valid,
    // Nonvolatile store
    output logic                    nv_save,
    output logic [15:0]             nv_deadband,
    output logic [15:0]             nv_offset,
    output logic [15:0]             nv_az_offset
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                dual_gain_enable;    // Automatic gain switch
    logic [3:0]          operating_selector;  // Command interpretation
    logic [15:0]         max_velocity_limit;  // RPM limit
    logic [15:0]         vscale;              // RPM per 10 V
    logic [15:0]         input_deadband;      // Millivolts
    logic signed [15:0]  input_offset_comp;   // Input units
    logic signed [15:0]  input_reading;       // Normalised input
    logic signed [15:0]  az_offset;           // Velocity trim, RPM
    logic                reading_valid;       // Stage one result
    logic signed [15:0]  processed;           // After offset, deadband
    logic                processed_valid;     // Stage two result
    logic                gain_high;           // Gain used now
    logic                zero_req;            // Auto-zero strobe
    logic                save_req;            // Save strobe
    logic [13:0]         tick_cnt;            // Sample divider
    logic                tick;                // Velocity sample enable
    logic                az_busy;             // Averaging running
    logic                az_done;             // Average ready
    logic signed [15:0]  az_average;          // Mean velocity
    logic signed [15:0]  next_reading;        // Normalised code
    logic signed [16:0]  offset_sum;          // Wide sum
    logic signed [15:0]  next_processed;      // Deadband result
    logic [15:0]         db_units;            // Deadband in units

    // Millivolts into internal units of 10 V / 16384
    function automatic logic [15:0] mv_to_units(input logic [15:0] mv);
        logic [31:0] p;
        p = 32'(mv) * 32'(aci_pkg::FULL_UNITS);
        p = p / 32'(aci_pkg::FULL_MV);
        return (p > 32'h7FFF) ? 16'h7FFF : p[15:0];
    endfunction : mv_to_units

    // ************************************************************
    // Register writes
    // ************************************************************
    // Status, reading: read only
    // Control register: gain switch and operating selector
    always_ff @(posedge clk) begin
        if (srst) begin
            dual_gain_enable   <= aci_pkg::DUAL_RST;
            operating_selector <= aci_pkg::SEL_RST;
        end else if (reg_wr && reg_addr == aci_pkg::REG_CTRL) begin
            dual_gain_enable   <= reg_wdata[aci_pkg::CTRL_DUAL_BIT];
            operating_selector <=
                reg_wdata[aci_pkg::CTRL_SEL_LSB +: 4];
        end
    end

    // Velocity limit and scale; the scale defaults to 1.25x limit
    // so that 8 V gives full speed
    always_ff @(posedge clk) begin
        if (srst) begin
            max_velocity_limit <= aci_pkg::MAX_VELOCITY_LIMIT_RST;
            vscale <= 16'((32'(aci_pkg::MAX_VELOCITY_LIMIT_RST) * 32'd5) >> 2);
        end else if (reg_wr) begin
            if (reg_addr == aci_pkg::REG_MAX_VELOCITY_LIMIT) begin
                max_velocity_limit <= reg_wdata;
            end
            if (reg_addr == aci_pkg::REG_VSCALE) begin
                vscale <= reg_wdata;
            end
        end
    end

    // Deadband: software writes it, a finished auto-zero sets it
    always_ff @(posedge clk) begin
        if (srst) begin
            input_deadband <= aci_pkg::DEADBAND_RST;
        end else if (az_done) begin
            // Hardware result wins over a write in the same cycle
            input_deadband <= aci_pkg::AZ_DEADBAND_MV;
        end else if (reg_wr && reg_addr == aci_pkg::REG_DEADBAND) begin
            input_deadband <= reg_wdata;
        end
    end

    // Offset compensation, written as the negated zero reading
    always_ff @(posedge clk) begin
        if (srst) begin
            input_offset_comp <= aci_pkg::OFFSET_RST;
        end else if (reg_wr && reg_addr == aci_pkg::REG_OFFSET) begin
            input_offset_comp <= reg_wdata;
        end
    end

    // Command strobes, one cycle each
    always_ff @(posedge clk) begin
        if (srst) begin
            zero_req <= 1'b0;
            save_req <= 1'b0;
        end else begin
            zero_req <= reg_wr && reg_addr == aci_pkg::REG_CMD &&
                        reg_wdata[aci_pkg::CMD_ZERO_BIT];
            save_req <= reg_wr && reg_addr == aci_pkg::REG_CMD &&
                        reg_wdata[aci_pkg::CMD_SAVE_BIT];
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    // Data stands in the cycle after the strobe only
    // Never inserts a wait
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                aci_pkg::REG_CTRL: begin
                    reg_rdata <= {8'h00, operating_selector, 3'h0,
                                  dual_gain_enable};
                end
                aci_pkg::REG_MAX_VELOCITY_LIMIT:      reg_rdata <= max_velocity_limit;
                aci_pkg::REG_VSCALE:    reg_rdata <= vscale;
                aci_pkg::REG_DEADBAND:  reg_rdata <= input_deadband;
                aci_pkg::REG_OFFSET:    reg_rdata <= input_offset_comp;
                aci_pkg::REG_READING:   reg_rdata <= input_reading;
                aci_pkg::REG_STATUS: begin
                    reg_rdata <= {13'h0000, drive_enabled, az_busy,
                                  gain_high};
                end
                aci_pkg::REG_AZ_OFFSET: reg_rdata <= az_offset;
                // Unmapped addresses read as zero
                default:                reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ************************************************************
    // Gain selection
    // ************************************************************
    // The gain is a level toward the analog front end; the
    // converter sample that arrives carries the gain that was set
    aci_gain_select u_gain (
        .clk              (clk),
        .srst             (srst),
        .dual_gain_enable (dual_gain_enable),
        .sample_valid     (reading_valid),
        .magnitude        (aci_pkg::mag16(input_reading)),
        .gain_high        (gain_high)
    );

    assign front_gain_high = gain_high;

    // ************************************************************
    // Stage one: normalise the code to 10 V / 16384 units
    // ************************************************************
    // High gain code: one step is 0.61 mV; low gain: 4.88 mV, so
    // the low gain code is multiplied by eight
    always_comb begin
        if (gain_high) begin
            next_reading = 16'(adc_code);
        end else begin
            next_reading = 16'(adc_code) <<< 3;
        end
    end

    // Holds between samples
    always_ff @(posedge clk) begin
        if (srst) begin
            input_reading    <= 16'sh0000;
            reading_valid    <= 1'b0;
        end else begin
            reading_valid <= adc_valid;
            if (adc_valid) begin
                input_reading    <= next_reading;
            end
        end
    end

    // ************************************************************
    // Stage two: offset then symmetric deadband
    // ************************************************************
    assign db_units   = mv_to_units(input_deadband);
    assign offset_sum = 17'(input_reading) + 17'(input_offset_comp);

    // Saturate the sum, then zero anything inside the band on
    // either side of zero
    always_comb begin
        // Symmetric clip
        if (offset_sum > 17'sh07FFF) begin
            next_processed = 16'sh7FFF;
        end else if (offset_sum < -17'sh07FFF) begin
            next_processed = -16'sh7FFF;
        end else begin
            next_processed = offset_sum[15:0];
        end
        if (aci_pkg::mag16(next_processed) < db_units) begin
            next_processed = 16'sh0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            processed       <= 16'sh0000;
            processed_valid <= 1'b0;
        end else begin
            processed_valid <= reading_valid;
            if (reading_valid) begin
                processed <= next_processed;
            end
        end
    end

    // ************************************************************
    // Stage three: scale into a velocity or torque command
    // ************************************************************
    // A 16384-unit full scale gives scale/2048 steps above 12.5 %
    // and scale/16384 below 10 %, where the high gain is active
    // Wide so it cannot wrap
    always_ff @(posedge clk) begin
        if (srst) begin
            vel_cmd          <= 24'sh000000;
            vel_cmd_valid    <= 1'b0;
            torque_cmd       <= 16'sh0000;
            torque_cmd_valid <= 1'b0;
        end else begin
            vel_cmd_valid    <= 1'b0;
            torque_cmd_valid <= 1'b0;
            if (processed_valid) begin
                unique case (operating_selector)
                    aci_pkg::SEL_ANALOG_VEL: begin
                        vel_cmd <= 24'((34'(processed) *
                                   34'(signed'({1'b0, vscale})))
                                   >>> aci_pkg::SCALE_SHIFT)
                                   + 24'(az_offset);
                        vel_cmd_valid <= 1'b1;
                    end
                    aci_pkg::SEL_ANALOG_TRQ: begin
                        torque_cmd       <= processed;
                        torque_cmd_valid <= 1'b1;
                    end
                    // Other selectors take commands elsewhere
                    default: begin
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Auto-zero
    // ************************************************************
    // One-cycle enable that paces velocity sampling
    // Free-running pace
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == 14'(AZ_TICK_CYC - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // Averaging only means something with the drive enabled and
    // no deadband hiding the offset; the request is simply taken
    // Repeat while busy is lost
    aci_averager #(
        .LOG2    (aci_pkg::AZ_LOG2)
    ) u_avg (
        .clk     (clk),
        .srst    (srst),
        .start   (zero_req && !az_busy),
        .tick    (tick),
        .sample  (motor_velocity),
        .busy    (az_busy),
        .done    (az_done),
        .average (az_average)
    );

    // Internal trim cancels the mean speed offset; it stays
    // volatile until saved
    always_ff @(posedge clk) begin
        if (srst) begin
            az_offset <= 16'sh0000;
        end else if (az_done) begin
            az_offset <= az_offset - az_average;
        end
    end

    // ************************************************************
    // Save to nonvolatile memory
    // ************************************************************
    // Snapshot is taken with the pulse so the store sees stable
    // data while it writes
    // Store takes every pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            nv_save      <= 1'b0;
            nv_deadband  <= 16'h0000;
            nv_offset    <= 16'h0000;
            nv_az_offset <= 16'h0000;
        end else begin
            nv_save <= save_req;
            if (save_req) begin
                nv_deadband  <= input_deadband;
                nv_offset    <= input_offset_comp;
                nv_az_offset <= az_offset;
            end
        end
    end

endmodule : aci_top

// [test/aci_props.sv]
`timescale 1ns/10ps
module aci_props #(
    parameter int AZ_TICK_CYC = 4
) (
    input wire logic               clk,
    input wire logic               srst,
    input wire logic [3:0]         reg_addr,
    input wire logic [15:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_rdata,
    input wire logic               adc_valid,
    input wire logic               front_gain_high,
    input wire logic signed [23:0] vel_cmd,
    input wire logic               vel_cmd_valid,
    input wire logic               torque_cmd_valid,
    input wire logic               nv_save,
    input wire logic [15:0]        nv_deadband,
    input wire logic [15:0]        nv_az_offset
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Save request on the command word
    sequence save_req; reg_wr && reg_addr == 4'h7 && reg_wdata[1]; endsequence
    // Any processed command leaving the block
    sequence cmd_out; vel_cmd_valid || torque_cmd_valid; endsequence
    a_read_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    a_out_latency: assert property (cmd_out |-> $past(adc_valid, 3))
        else $error("command without sample");
    a_one_meaning: assert property (!(vel_cmd_valid &&
        torque_cmd_valid))
        else $error("both meanings at once");
    a_save_delay: assert property (save_req |-> ##2 nv_save)
        else $error("save pulse missing");
    a_save_cause: assert property (nv_save |-> $past(reg_wr, 2))
        else $error("save pulse without write");
    a_nv_stands: assert property (!nv_save |->
        $stable(nv_deadband) && $stable(nv_az_offset))
        else $error("stored values moved");
    a_dual_low: assert property ((reg_wr && reg_addr == 4'h0 &&
        !reg_wdata[0]) |-> ##[1:2] !front_gain_high)
        else $error("gain not forced low");
    a_gain_cause: assert property ($changed(front_gain_high) |->
        $past(adc_valid, 2) || $past(adc_valid, 3) ||
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("gain moved without cause");
    a_reset_state: assert property ($fell(srst) |-> front_gain_high &&
        !vel_cmd_valid && !nv_save)
        else $error("bad state after reset");
    a_vel_holds: assert property (!vel_cmd_valid |-> $stable(vel_cmd))
        else $error("velocity moved between results");
endmodule : aci_props
bind aci_top aci_props #(.AZ_TICK_CYC(AZ_TICK_CYC)) u_props (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_valid(adc_valid), .front_gain_high(front_gain_high),
    .vel_cmd(vel_cmd), .vel_cmd_valid(vel_cmd_valid),
    .torque_cmd_valid(torque_cmd_valid), .nv_save(nv_save),
    .nv_deadband(nv_deadband), .nv_az_offset(nv_az_offset));

// [test/aci_source.sv]
`timescale 1ns/10ps
// Command source plus front end: converts a millivolt level on request
module aci_source (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               go,
    input  wire logic signed [15:0] lvl,
    input  wire logic               front_gain_high,
    output logic                    adc_valid,
    output logic signed [11:0]      adc_code
);
    int c; // Unclipped code
    // High gain is eight times finer than the plain 20 V / 4096 step
    assign c = front_gain_high ? int'(lvl) * 16384 / 10000
                               : int'(lvl) * 2048 / 10000;
    // Idle code toggles so a stale value never looks valid
    always_ff @(posedge clk) begin
        if (srst) begin
            adc_valid <= 1'b0;
            adc_code  <= 12'h000;
        end else begin
            adc_valid <= go;
            adc_code  <= !go ? ~adc_code : c > 2047 ? 12'h7FF
                       : c < -2048 ? 12'h800 : 12'(c);
        end
    end
endmodule : aci_source

// [test/analog_command_input_tb_top.sv]
`timescale 1ns/10ps
module analog_command_input_tb_top;
    logic               clk = 1'b0, srst = 1'b1, go = 1'b0, rd_d = 1'b0;
    logic               reg_wr = 1'b0, reg_rd = 1'b0, drive_enabled = 1'b0;
    logic [3:0]         reg_addr = 4'h0;
    logic [15:0]        reg_wdata = 16'h0000;
    logic signed [15:0] motor_velocity = 16'h0000, lvl = 16'h0000;
    logic               adc_valid, front_gain_high, vel_cmd_valid;
    logic               torque_cmd_valid, nv_save;
    logic signed [11:0] adc_code;
    logic [15:0]        reg_rdata, nv_deadband, nv_offset, nv_az_offset;
    logic signed [23:0] vel_cmd;
    logic signed [15:0] torque_cmd;
    logic [23:0]        rq[$], cq[$]; // Expected reads and commands
    int err_count = 0, check_count = 0, off = 0, db = 0, az = 0, vs;
    int seed = 32'h507C0A49;
    always #50 clk = ~clk;
    aci_top #(.AZ_TICK_CYC(4)) dut (.clk(clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
        .adc_code(adc_code), .front_gain_high(front_gain_high),
        .drive_enabled(drive_enabled), .motor_velocity(motor_velocity),
        .vel_cmd(vel_cmd), .vel_cmd_valid(vel_cmd_valid),
        .torque_cmd(torque_cmd), .torque_cmd_valid(torque_cmd_valid),
        .nv_save(nv_save), .nv_deadband(nv_deadband),
        .nv_offset(nv_offset), .nv_az_offset(nv_az_offset));
    aci_source src (.clk(clk), .srst(srst), .go(go), .lvl(lvl),
        .front_gain_high(front_gain_high), .adc_valid(adc_valid),
        .adc_code(adc_code));
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task print_verdict;
        $display("mismatches %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // One-cycle bus strobes, a gap cycle after each
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a; rq.push_back({8'h00, e});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // Offset, clip, then symmetric deadband
    function automatic int sum_of(input int mv, input bit g);
        int c, s;
        c = g ? mv * 16384 / 10000 : mv * 2048 / 10000;
        c = c > 2047 ? 2047 : c < -2048 ? -2048 : c;
        s = (g ? c : c * 8) + off;
        s = s > 32767 ? 32767 : s < -32767 ? -32767 : s;
        return ((s < 0 ? -s : s) < db * 16384 / 10000) ? 0 : s;
    endfunction : sum_of
    // One sample; k: 0 none, 1 velocity, 2 torque
    task smp(input int mv, input bit g, input int k);
        @(posedge clk);
        go <= 1'b1; lvl <= 16'(mv);
        @(posedge clk);
        go <= 1'b0;
        if (k == 1) cq.push_back(24'(((sum_of(mv, g) * vs) >>> 14) + az));
        if (k == 2) cq.push_back(24'(sum_of(mv, g)));
        repeat (5) @(posedge clk);
    endtask : smp
    // Oldest note, unknown when none
    function automatic logic [23:0] nxt(input bit r);
        if (r) return rq.size() ? rq.pop_front() : 24'hXXXXXX;
        return cq.size() ? cq.pop_front() : 24'hXXXXXX;
    endfunction : nxt
    // Result watcher pops the oldest note
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk({8'h00, reg_rdata}, nxt(1'b1));
        if (vel_cmd_valid) chk(vel_cmd, nxt(1'b0));
        if (torque_cmd_valid) chk(24'(torque_cmd), nxt(1'b0));
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(4'h0, 16'h0001); rd(4'h1, 16'h0C80); rd(4'h9, 16'h0000);
        rd(4'h2, 16'h0FA0);
        vs = $random(seed) & 16'h3FFF;
        wr(4'h2, 16'(vs)); wr(4'h0, 16'h0011);
        smp(500, 1, 1); rd(4'h5, 16'h0333);
        smp(1200, 1, 1); smp(-1300, 1, 1); smp(1100, 0, 1);
        smp(900, 0, 1); smp(900, 1, 1);
        db = 100; wr(4'h3, 16'h0064);
        smp(50, 1, 1); smp(-120, 1, 1); smp(-90, 1, 1);
        off = 200; wr(4'h4, 16'h00C8);
        smp(50, 1, 1); smp(-50, 1, 1);
        wr(4'h0, 16'h0010); repeat (2) @(posedge clk);
        smp(500, 0, 1);
        wr(4'h0, 16'h0031); smp(500, 0, 2);
        wr(4'h0, 16'h0001); smp(500, 1, 0);
        wr(4'h0, 16'h0011); off = 0; wr(4'h4, 16'h0000);
        db = 0; wr(4'h3, 16'h0000);
        drive_enabled <= 1'b1; motor_velocity <= 16'h000C;
        wr(4'h7, 16'h0001); repeat (1040) @(posedge clk);
        az = -12; db = 2; rd(4'h3, 16'h0002); smp(0, 1, 1);
        rd(4'h6, 16'h0005); rd(4'h8, 16'hFFF4);
        wr(4'h4, 16'h00C8); wr(4'h7, 16'h0002); repeat (3) @(posedge clk);
        chk(24'(nv_deadband), 24'h000002);
        chk(24'(nv_offset), 24'h0000C8);
        chk(24'(nv_az_offset), 24'h00FFF4);
        print_verdict;
    end
endmodule : analog_command_input_tb_top
